// >>> core/spcf_regs.svh
`ifndef SPCF_REGS_SVH
`define SPCF_REGS_SVH

// software port offsets (byte addresses)
`define SPCF_OFS_CTRL        10'h000
`define SPCF_OFS_STATUS      10'h004
`define SPCF_OFS_DIAG        10'h008
`define SPCF_OFS_BANK        10'h100
`define SPCF_BANK_WORDS      6'h24

// control and status fields
`define SPCF_CTRL_SOFT_RST   0
`define SPCF_STAT_FAULT      0
`define SPCF_STAT_RST_REPLY  1
`define SPCF_STAT_SYNTAX     2
`define SPCF_STAT_FRAMES_LSB 8

// diagnosis word
`define SPCF_DIAG_FAULT_BIT  10
`define SPCF_DIAG_RESET      15'h7800
`define SPCF_RESET_REPLY     16'h7C00

// command prefixes and trailers
`define SPCF_PFX_WRITE       2'h2
`define SPCF_PFX_READ        2'h1
`define SPCF_PFX_BAD_WRITE   2'h3
`define SPCF_PFX_BAD_READ    2'h0
`define SPCF_TAIL_DIAG       2'h1
`define SPCF_TAIL_READ       2'h2

// primary address map
`define SPCF_FIRST_WORD_REG  4'h8
`define SPCF_FIRST_RESERVED  4'hC
`define SPCF_WORD_BASE_IDX   6'h20

// valid frame lengths in clock pulses, then the count ceiling
`define SPCF_LEN_BASE        6'h10
`define SPCF_LEN_PLUS1       6'h18
`define SPCF_LEN_PLUS2       6'h20
`define SPCF_LEN_MAX         6'h3F

`endif

// >>> core/spcf_pkg.sv
package spcf_pkg;

    typedef enum logic [1:0]
    {
        SPCF_IDLE  = 2'h0,
        SPCF_SHIFT = 2'h1,
        SPCF_END   = 2'h3
    } spcf_phase_e;

    typedef struct packed
    {
        logic [1:0] prefix;
        logic [3:0] primary_address_field;
        logic [1:0] secondary_address_field;
        logic [5:0] middle;
        logic [1:0] tail;
    } spcf_frame_s;

    typedef struct packed
    {
        spcf_phase_e phase;
        logic        sel_q;
        logic        sclk_q;
        logic [5:0]  count;
        logic        si_bit;
        logic [15:0] sr;
        logic [15:0] rx;
        logic [15:0] reply;
        logic        fault;
        logic        rst_reply;
        logic        syn_err;
        logic [7:0]  frames;
        logic        so;
        logic        so_oe_n;
        logic [31:0] rdata;
        logic [14:0] diag;
    } spcf_state_s;

endpackage

// >>> core/spcf_sync.sv
`timescale 1ns/1ps
module spcf_sync #(
    parameter int          WIDTH = 3,
    parameter logic [2:0]  INIT  = 3'h0
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            // first stage feeds only the second stage
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    stage1[i]   <= INIT[i];
                    sync_out[i] <= INIT[i];
                end
                else
                begin
                    stage1[i]   <= async_in[i];
                    sync_out[i] <= stage1[i];
                end
            end
        end
    endgenerate
endmodule

// >>> core/spcf_regbank.sv
`timescale 1ns/1ps
`include "spcf_regs.svh"
module spcf_regbank (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       clear,
    input  wire logic       we,
    input  wire logic [5:0] wr_idx,
    input  wire logic [9:0] wdata,
    input  wire logic [5:0] rd_idx_a,
    input  wire logic [5:0] rd_idx_b,
    output logic      [9:0] rd_a,
    output logic      [9:0] rd_b
);
    // 32 byte registers then 4 ten-bit registers
    logic [9:0] mem [0:35];

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int k = 0; k < 36; k++)
                mem[k] <= 10'h000;
        end
        else if (clear)
        begin
            for (int k = 0; k < 36; k++)
                mem[k] <= 10'h000;
        end
        else if (we && wr_idx < `SPCF_BANK_WORDS)
        begin
            mem[wr_idx] <= wdata;
        end
    end

    always_comb
    begin
        rd_a = (rd_idx_a < `SPCF_BANK_WORDS) ? mem[rd_idx_a] : 10'h000;
        rd_b = (rd_idx_b < `SPCF_BANK_WORDS) ? mem[rd_idx_b] : 10'h000;
    end
endmodule

// >>> core/spcf_frame.sv
`timescale 1ns/1ps
`include "spcf_regs.svh"
module spcf_frame (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        select_low,
    input  wire logic        sclk,
    input  wire logic        si,
    output logic             so,
    output logic             so_oe_n,
    input  wire logic [9:0]  address,
    input  wire logic [31:0] write_data,
    input  wire logic        write_strobe,
    input  wire logic        read_strobe,
    output logic      [31:0] read_data
);
    spcf_pkg::spcf_state_s q;
    spcf_pkg::spcf_state_s next_q;
    spcf_pkg::spcf_frame_s cmd;

    logic [2:0] pins_s;
    logic       sel_s;
    logic       sclk_s;
    logic       si_s;
    logic       sel_fall;
    logic       sel_rise;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       valid_len;
    logic       reserved;
    logic [14:0] diag_ok;
    logic [15:0] diag_word;
    logic       bank_clear;
    logic       bank_we;
    logic [5:0] spi_idx;
    logic [5:0] sw_idx;
    logic [9:0] spi_rd;
    logic [9:0] sw_rd;

    // select idles high, clock and data idle low
    spcf_sync #(
        .WIDTH (3),
        .INIT  (3'h4)
    ) u_sync (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in ({select_low, sclk, si}),
        .sync_out (pins_s)
    );

    assign sel_s  = pins_s[2];
    assign sclk_s = pins_s[1];
    assign si_s   = pins_s[0];

    spcf_regbank u_bank (
        .clk      (clk),
        .reset_n  (reset_n),
        .clear    (bank_clear),
        .we       (bank_we),
        .wr_idx   (spi_idx),
        .wdata    (cmd.primary_address_field >= `SPCF_FIRST_WORD_REG
                   ? q.rx[9:0] : {2'h0, q.rx[7:0]}),
        .rd_idx_a (spi_idx),
        .rd_idx_b (sw_idx),
        .rd_a     (spi_rd),
        .rd_b     (sw_rd)
    );

    assign cmd      = spcf_pkg::spcf_frame_s'(q.rx);
    assign sw_idx   = address[7:2];
    assign sel_fall = q.sel_q & ~sel_s;
    assign sel_rise = ~q.sel_q & sel_s;
    assign sclk_rise = ~q.sclk_q & sclk_s;
    assign sclk_fall = q.sclk_q & ~sclk_s;

    assign valid_len = (q.count == `SPCF_LEN_BASE)
                    || (q.count == `SPCF_LEN_PLUS1)
                    || (q.count == `SPCF_LEN_PLUS2);

    assign reserved = cmd.primary_address_field >= `SPCF_FIRST_RESERVED;

    always_comb
    begin
        if (cmd.primary_address_field >= `SPCF_FIRST_WORD_REG)
            spi_idx = `SPCF_WORD_BASE_IDX
                    + {4'h0, cmd.primary_address_field[1:0]};
        else
            spi_idx = {1'b0, cmd.primary_address_field[2:0],
                       cmd.secondary_address_field};
    end

    // fault flag merged at bit 10
    always_comb
    begin
        diag_ok = q.diag;
        diag_ok[`SPCF_DIAG_FAULT_BIT] = ~valid_len;
        diag_word = {1'b0, diag_ok};
    end

    always_comb
    begin
        next_q = q;
        bank_we = 1'b0;
        bank_clear = 1'b0;
        next_q.sel_q = sel_s;
        next_q.sclk_q = sclk_s;

        unique case (q.phase)
            spcf_pkg::SPCF_IDLE:
            begin
                // msb drives out as soon as selected
                if (sel_fall)
                begin
                    next_q.phase = spcf_pkg::SPCF_SHIFT;
                    next_q.count = 6'h00;
                    next_q.sr = q.reply;
                    next_q.so = q.reply[15];
                    next_q.so_oe_n = 1'b0;
                end
            end
            spcf_pkg::SPCF_SHIFT:
            begin
                if (sel_rise)
                begin
                    next_q.phase = spcf_pkg::SPCF_END;
                    next_q.so_oe_n = 1'b1;
                    next_q.so = 1'b0;
                    next_q.rx = {q.sr[14:0], q.si_bit};
                end
                else
                begin
                    if (sclk_fall)
                    begin
                        next_q.si_bit = si_s;
                        // saturate so long frames stay invalid
                        if (q.count != `SPCF_LEN_MAX)
                            next_q.count = q.count + 6'h01;
                    end
                    // first rising edge keeps the msb already shown
                    if (sclk_rise && q.count != 6'h00)
                    begin
                        next_q.sr = {q.sr[14:0], q.si_bit};
                        next_q.so = q.sr[14];
                    end
                end
            end
            spcf_pkg::SPCF_END:
            begin
                // answer parked for the next frame
                next_q.phase = spcf_pkg::SPCF_IDLE;
                next_q.frames = q.frames + 8'h01;
                next_q.fault = ~valid_len;
                next_q.syn_err = 1'b0;
                next_q.reply = diag_word;
                if (q.rst_reply)
                begin
                    // command of this frame not answered
                    // second reply is the diagnosis word
                    next_q.rst_reply = 1'b0;
                end
                else if (!valid_len)
                begin
                    // nothing executed on a bad length
                    next_q.reply = diag_word;
                end
                else
                begin
                    unique case (cmd.prefix)
                        `SPCF_PFX_WRITE:
                        begin
                            if (reserved)
                                next_q.syn_err = 1'b1;
                            else
                                bank_we = 1'b1;
                        end
                        `SPCF_PFX_READ:
                        begin
                            if (cmd.tail == `SPCF_TAIL_DIAG)
                                next_q.reply = diag_word;
                            else if (cmd.tail == `SPCF_TAIL_READ
                                     && !reserved)
                            begin
                                if (cmd.primary_address_field
                                    >= `SPCF_FIRST_WORD_REG)
                                    next_q.reply = {`SPCF_PFX_WRITE,
                                        cmd.primary_address_field,
                                        spi_rd};
                                else
                                    next_q.reply = {`SPCF_PFX_WRITE,
                                        cmd.primary_address_field,
                                        cmd.secondary_address_field,
                                        spi_rd[7:0]};
                            end
                            else
                                next_q.syn_err = 1'b1;
                        end
                        `SPCF_PFX_BAD_READ:
                        begin
                            // bit 15 clear with trailer 01
                            if (cmd.tail != `SPCF_TAIL_DIAG)
                                next_q.syn_err = 1'b1;
                        end
                        `SPCF_PFX_BAD_WRITE:
                        begin
                            next_q.syn_err = 1'b1;
                        end
                    endcase
                    // syntax error leaves bank, gives diagnosis
                    if (next_q.syn_err)
                        next_q.reply = diag_word;
                end
            end
        endcase

        // software port; read data valid for one cycle only
        next_q.rdata = 32'h0000_0000;
        if (read_strobe)
        begin
            if (address == `SPCF_OFS_STATUS)
            begin
                next_q.rdata[`SPCF_STAT_FAULT] = q.fault;
                next_q.rdata[`SPCF_STAT_RST_REPLY] = q.rst_reply;
                next_q.rdata[`SPCF_STAT_SYNTAX] = q.syn_err;
                next_q.rdata[`SPCF_STAT_FRAMES_LSB +: 8] = q.frames;
            end
            else if (address == `SPCF_OFS_DIAG)
                next_q.rdata = {17'h0_0000, q.diag};
            else if (address[9:8] == 2'h1 && address[1:0] == 2'h0
                     && sw_idx < `SPCF_BANK_WORDS)
                next_q.rdata = {22'h00_0000, sw_rd};
        end

        if (write_strobe && address == `SPCF_OFS_DIAG)
        begin
            next_q.diag = write_data[14:0];
            // flag bit is owned by the frame checker
            next_q.diag[`SPCF_DIAG_FAULT_BIT] = 1'b0;
        end

        // soft reset wins over a frame finishing now
        // first reply carries the flag and cleared instruction reg
        if (write_strobe && address == `SPCF_OFS_CTRL
            && write_data[`SPCF_CTRL_SOFT_RST])
        begin
            bank_clear = 1'b1;
            bank_we = 1'b0;
            next_q.rst_reply = 1'b1;
            next_q.fault = 1'b1;
            next_q.reply = `SPCF_RESET_REPLY;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            q <= '0;
            q.phase <= spcf_pkg::SPCF_IDLE;
            q.sel_q <= 1'b1;
            q.so_oe_n <= 1'b1;
            q.fault <= 1'b1;
            q.rst_reply <= 1'b1;
            q.reply <= `SPCF_RESET_REPLY;
            q.diag <= `SPCF_DIAG_RESET;
        end
        else
        begin
            q <= next_q;
        end
    end

    assign so = q.so;
    assign so_oe_n = q.so_oe_n;
    assign read_data = q.rdata;
endmodule

// >>> tb/spcf_frame_props.sv
`timescale 1ns/1ps
module spcf_frame_props (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        select_low,
    input wire logic        sclk,
    input wire logic        si,
    input wire logic        so,
    input wire logic        so_oe_n,
    input wire logic [9:0]  address,
    input wire logic [31:0] write_data,
    input wire logic        write_strobe,
    input wire logic        read_strobe,
    input wire logic [31:0] read_data
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // sync delay of select leaves a few cycles of slack
    a_so_released: assert property (select_low [*6] |-> so_oe_n)
        else $error("so driven while deselected");
    a_so_enabled: assert property (
        $fell(select_low) |-> ##[1:6] !so_oe_n)
        else $error("so not driven after select");
    a_released_zero: assert property (so_oe_n |-> !so)
        else $error("so not parked while released");
    // bits move only after a rising serial clock
    a_so_steady: assert property (
        $fell(sclk) && !select_low |=> $stable(so) [*3])
        else $error("so moved after falling sclk");
    a_rd_idle: assert property (
        !$past(read_strobe) |-> read_data == 32'h0000_0000)
        else $error("read data outside read cycle");
    a_ctrl_zero: assert property (
        read_strobe && address == 10'h000 |=> read_data == 32'h0)
        else $error("control register not read as zero");
    a_unmapped_zero: assert property (
        read_strobe && address == 10'h00C |=> read_data == 32'h0)
        else $error("unmapped read not zero");
    a_byte_width: assert property (
        read_strobe && address >= 10'h100 && address < 10'h180
        |=> read_data[31:8] == 24'h00_0000)
        else $error("byte register wider than 8 bits");
    a_word_width: assert property (
        read_strobe && address >= 10'h180 && address < 10'h190
        |=> read_data[31:10] == 22'h00_0000)
        else $error("word register wider than 10 bits");
    a_diag_fault_low: assert property (
        read_strobe && address == 10'h008
        |=> read_data[10] == 1'b0 && read_data[31:15] == 17'h0_0000)
        else $error("diagnosis source bits out of range");
    a_reset_quiet: assert property (
        $rose(reset_n) |-> so_oe_n && read_data == 32'h0)
        else $error("outputs active right after reset");
endmodule

bind spcf_frame spcf_frame_props spcf_frame_props_i (
    .clk          (clk),
    .reset_n      (reset_n),
    .select_low   (select_low),
    .sclk         (sclk),
    .si           (si),
    .so           (so),
    .so_oe_n      (so_oe_n),
    .address      (address),
    .write_data   (write_data),
    .write_strobe (write_strobe),
    .read_strobe  (read_strobe),
    .read_data    (read_data)
);

// >>> tb/spcf_master.sv
`timescale 1ns/1ps
module spcf_master (
    output logic      select_low,
    output logic      sclk,
    output logic      si,
    input  wire logic so,
    input  wire logic so_oe_n
);
    logic last_so;
    logic miso;

    initial
    begin
        select_low = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
        last_so = 1'b0;
    end

    // released line shows no stale bit
    always @(so or so_oe_n)
        if (!so_oe_n)
            last_so = so;
    assign miso = so_oe_n ? ~last_so : so;

    task automatic xfer(input int n, input logic [31:0] cmd,
                        output logic [15:0] rx);
        int k;
        rx = 16'h0000;
        #7;
        select_low = 1'b0;
        #165;
        for (k = n - 1; k >= 0; k--)
        begin
            // si moves early in the low phase, after the sync caught the fall
            #35;
            si = cmd[k];
            #42;
            sclk = 1'b1;
            #83;
            if (n - 1 - k < 16)
                rx = {rx[14:0], miso};
            sclk = 1'b0;
        end
        #35;
        si = 1'b0;
        #65;
        select_low = 1'b1;
        #400;
    endtask
endmodule

// >>> tb/spcf_frame_tb.sv
`timescale 1ns/1ps
module spcf_frame_tb;
    logic        clk;
    logic        reset_n;
    logic        select_low;
    logic        sclk;
    logic        si;
    logic        so;
    logic        so_oe_n;
    logic [9:0]  address;
    logic [31:0] write_data;
    logic        write_strobe;
    logic        read_strobe;
    logic [31:0] read_data;
    int          n_errors;
    int          samples_checked;

    spcf_frame spcf_frame_i (
        .clk          (clk),
        .reset_n      (reset_n),
        .select_low   (select_low),
        .sclk         (sclk),
        .si           (si),
        .so           (so),
        .so_oe_n      (so_oe_n),
        .address      (address),
        .write_data   (write_data),
        .write_strobe (write_strobe),
        .read_strobe  (read_strobe),
        .read_data    (read_data)
    );

    spcf_master spcf_master_i (
        .select_low (select_low),
        .sclk       (sclk),
        .si         (si),
        .so         (so),
        .so_oe_n    (so_oe_n)
    );

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic close_out;
        if (n_errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check_rd(input logic [9:0] a, input logic [31:0] exp);
        samples_checked++;
        if (read_data !== exp)
        begin
            n_errors++;
            $display("mismatch read %h expected %h seen %h", a, exp,
                     read_data);
        end
    endtask

    task automatic check_reply(input logic [15:0] exp,
                               input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch reply expected %h seen %h", exp, got);
        end
    endtask

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge clk);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clk);
        write_strobe <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] a, input logic [31:0] exp);
        @(posedge clk);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clk);
        read_strobe <= 1'b0;
        #1;
        check_rd(a, exp);
    endtask

    // expectation is the answer to the previous command
    task automatic frame(input int n, input logic [31:0] cmd,
                         input logic [15:0] exp);
        logic [15:0] got;
        spcf_master_i.xfer(n, cmd, got);
        check_reply(exp, got);
    endtask

    initial
    begin
        repeat (40000) @(posedge clk);
        n_errors++;
        close_out;
    end

    initial
    begin
        n_errors = 0;
        samples_checked = 0;
        reset_n = 1'b0;
        address = 10'h000;
        write_data = 32'h0000_0000;
        write_strobe = 1'b0;
        read_strobe = 1'b0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(10'h004, 32'h0000_0003);
        rd(10'h00C, 32'h0000_0000);
        rd(10'h000, 32'h0000_0000);
        // fault bit written high must read back low from the diagnosis register
        wr(10'h008, 32'h0000_2EBC);
        rd(10'h008, 32'h0000_2ABC);
        frame(16, 32'h0001, 16'h7C00);
        frame(16, 32'h9A55, 16'h2ABC);
        frame(16, 32'h5A02, 16'h2ABC);
        frame(16, 32'hA6A5, 16'h9A55);
        frame(16, 32'h6402, 16'h2ABC);
        frame(16, 32'hDA77, 16'hA6A5);
        frame(16, 32'h1A02, 16'h2ABC);
        frame(16, 32'hB0FF, 16'h2ABC);
        // eight frames done, last one a syntax error
        rd(10'h004, 32'h0000_0804);
        frame(20, 32'h0_0001, 16'h2ABC);
        // only twelve reply bits come out of a short frame
        frame(12, 32'h001, 16'h02EB);
        frame(24, 32'h00_0001, 16'h2EBC);
        frame(32, 32'h0000_5A02, 16'h2ABC);
        frame(16, 32'h0001, 16'h9A55);
        rd(10'h168, 32'h0000_0055);
        rd(10'h184, 32'h0000_02A5);
        rd(10'h17C, 32'h0000_0000);
        // reserved write must not land in the instruction register
        rd(10'h180, 32'h0000_0000);
        wr(10'h000, 32'h0000_0001);
        frame(16, 32'h9A11, 16'h7C00);
        frame(16, 32'h5A02, 16'h2ABC);
        frame(16, 32'h0001, 16'h9A00);
        close_out;
    end
endmodule
